// >>> pkg/hom_pkg.sv
// package for the host operating-mode control register block
package hom_pkg;
  localparam logic [7:0] HOM_CTRL_OFFSET = 8'h04;
  localparam int RWE_BIT = 10;
  localparam int RWC_BIT = 9;
  localparam int IR_BIT = 8;
  localparam int FS_LSB = 6;
  localparam int BLE_BIT = 5;
  localparam logic [31:0] HOM_CTRL_RESET = 32'h0000_0000;
  // bits 31..11 reserved, bits 4..0 held outside this block
  localparam logic [31:0] HOM_WRITE_MASK = 32'h0000_07E0;
  localparam int SOF_DELAY_NS = 1000000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SOF_DELAY_CYCLES = SOF_DELAY_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    STATE_RESET = 2'h0,
    STATE_RESUME = 2'h1,
    STATE_OPERATIONAL = 2'h2,
    STATE_SUSPEND = 2'h3
  } hom_fstate_t;
endpackage

// >>> verilog/hom_ctrl.sv
// upper part of the host operating-mode control register
`timescale 1ns/10ps
`default_nettype none
module hom_ctrl
  import hom_pkg::*;
#(
  parameter int SofDelayCycles = SOF_DELAY_CYCLES
)(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic softReset,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  input wire logic resumeDetected,
  input wire logic downstreamResume,
  input wire logic statusEvent,
  input wire logic frameStart,
  output logic remoteWakeup,
  output logic hostBusIrq,
  output logic mgmtIrq,
  output logic frameStartFlag,
  output logic bulkActive,
  output logic rootHubReset
);
  typedef struct packed {
    logic remote_wakeup_enable;
    logic remote_wakeup_connected;
    logic ir;
    hom_fstate_t fs;
    logic bulk_queue_on;
    logic bulkRun;
    logic sofRun;
    logic sofFlag;
    logic [31:0] cnt;
    logic [31:0] rdata;
    logic hubReset;
  } hom_state_t;

  hom_state_t s_q, s_d;

  function automatic logic hitCtrl(input logic [7:0] a);
    hitCtrl = (a == HOM_CTRL_OFFSET);
  endfunction

  always_comb
  begin
    s_d = s_q;
    s_d.hubReset = 1'b0;
    if (regWrite && hitCtrl(regAddr))
    begin
      s_d.remote_wakeup_enable = regWdata[RWE_BIT];
      s_d.remote_wakeup_connected = regWdata[RWC_BIT];
      s_d.ir = regWdata[IR_BIT];
      s_d.fs = hom_fstate_t'(regWdata[FS_LSB +: 2]);
      s_d.bulk_queue_on = regWdata[BLE_BIT];
    end
    else if (s_q.fs == STATE_SUSPEND && downstreamResume)
    begin
      s_d.fs = STATE_RESUME;
    end
    if (s_d.fs == STATE_OPERATIONAL && s_q.fs != STATE_OPERATIONAL)
    begin
      s_d.cnt = 32'h0000_0000;
      s_d.sofRun = 1'b0;
      s_d.sofFlag = 1'b0;
    end
    else if (s_q.fs == STATE_OPERATIONAL && !s_q.sofRun)
    begin
      if (s_q.cnt >= 32'(SofDelayCycles - 1))
      begin
        s_d.sofRun = 1'b1;
        s_d.sofFlag = 1'b1;
      end
      else
      begin
        s_d.cnt = s_q.cnt + 32'h0000_0001;
      end
    end
    if (s_d.fs != STATE_OPERATIONAL)
    begin
      s_d.sofRun = 1'b0;
    end
    if (frameStart && s_q.sofRun)
    begin
      s_d.bulkRun = s_q.bulk_queue_on;
    end
    if (!s_d.sofRun)
    begin
      s_d.bulkRun = 1'b0;
    end
    if (softReset)
    begin
      s_d.fs = STATE_SUSPEND;
      s_d.sofRun = 1'b0;
      s_d.bulkRun = 1'b0;
    end
    s_d.rdata = 32'h0000_0000;
    if (regRead && hitCtrl(regAddr))
    begin
      s_d.rdata[RWE_BIT] = s_q.remote_wakeup_enable;
      s_d.rdata[RWC_BIT] = s_q.remote_wakeup_connected;
      s_d.rdata[IR_BIT] = s_q.ir;
      s_d.rdata[FS_LSB +: 2] = s_q.fs;
      s_d.rdata[BLE_BIT] = s_q.bulk_queue_on;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
      s_q.fs <= STATE_RESET;
      s_q.hubReset <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign remoteWakeup = s_q.remote_wakeup_enable & resumeDetected;
  assign hostBusIrq = statusEvent & ~s_q.ir;
  assign mgmtIrq = statusEvent & s_q.ir;
  assign frameStartFlag = s_q.sofFlag;
  assign bulkActive = s_q.bulkRun;
  assign regRdata = s_q.rdata;
  assign rootHubReset = s_q.hubReset | (s_q.fs == STATE_RESET);
endmodule // hom_ctrl
`default_nettype wire

// >>> testbench/hom_ctrl_checker.sv
// checker for the mode control block
`timescale 1ns/10ps
`default_nettype none
module hom_ctrl_checker (
  input wire logic mclk, reset_n, softReset, regWrite, regRead, frameStart,
  input wire logic resumeDetected, statusEvent, remoteWakeup, hostBusIrq,
  input wire logic mgmtIrq, frameStartFlag, bulkActive, rootHubReset,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regRdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_wake_cause: assert property (remoteWakeup |-> resumeDetected) else $error("wake");
  a_irq_cause: assert property ((hostBusIrq || mgmtIrq) == statusEvent) else $error("irq");
  a_irq_steer: assert property (mgmtIrq |-> !hostBusIrq) else $error("steer");
  a_soft_state: assert property (softReset |=> !rootHubReset) else $error("soft");
  a_flag_clear: assert property ($fell(frameStartFlag) |-> $past(regWrite || softReset))
    else $error("sof");
  a_bulk_hold: assert property (!$stable(bulkActive) |-> $past(frameStart || softReset))
    else $error("bulk");
  a_rsv_zero: assert property ((regRdata & 32'hFFFF_F81F) == 0) else $error("rsv");
  a_read_zero: assert property (regRdata != 0 |-> $past(regRead && regAddr == 8'h04))
    else $error("rd");
endmodule // hom_ctrl_checker
bind hom_ctrl hom_ctrl_checker i_hom_ctrl_checker(.*);
`default_nettype wire

// >>> testbench/hom_ctrl_test.sv
// bench for the mode control block
`timescale 1ns/10ps
`default_nettype none
module hom_ctrl_test;
  logic mclk = 0, reset_n = 0, softReset = 0, regWrite = 0, regRead = 0, frameStart = 0;
  logic resumeDetected = 0, downstreamResume = 0, statusEvent = 0;
  logic [7:0] regAddr = 8'h04;
  logic [31:0] regWdata = 0, regRdata;
  logic remoteWakeup, hostBusIrq, mgmtIrq, frameStartFlag, bulkActive, rootHubReset;
  int err_total = 0, cmp_count = 0;
  // short start-of-frame delay keeps the run brief
  hom_ctrl #(.SofDelayCycles(20)) i_hom_ctrl(.*);
  initial forever #2 mclk = ~mclk;
  task chk(string n, logic [31:0] s, e);
    cmp_count++;
    err_total += (s !== e);
    if (s !== e) $display("Error %s exp %h got %h", n, e, s);
  endtask
  task wr(logic [31:0] d);
    @(posedge mclk) regWrite <= 1;
    regWdata <= d;
    @(posedge mclk) regWrite <= 0;
  endtask
  task rd(logic [7:0] a, logic [31:0] e);
    @(posedge mclk) regRead <= 1;
    regAddr <= a;
    @(posedge mclk) regRead <= 0;
    #1 chk("rdata", regRdata, e);
  endtask
  task end_sim;
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #2000 err_total++;
    end_sim;
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    chk("hub", rootHubReset, 1);
    reset_n <= 1;
    rd(8'h08, 0);
    rd(8'h04, 0);
    wr(32'h0000_07E0);
    rd(8'h04, 32'h7E0);
    @(posedge mclk) statusEvent <= 1;
    resumeDetected <= 1;
    #1 chk("irq", {remoteWakeup, mgmtIrq, hostBusIrq}, 3'b110);
    wr(32'h0C0);
    #1 chk("irq", {remoteWakeup, mgmtIrq, hostBusIrq}, 3'b001);
    @(posedge mclk) downstreamResume <= 1;
    @(posedge mclk) downstreamResume <= 0;
    rd(8'h04, 32'h040);
    wr(32'h7A0);
    repeat (17) @(posedge mclk);
    #1 chk("sof", frameStartFlag, 0);
    repeat (5) @(posedge mclk);
    #1 chk("sof", frameStartFlag, 1);
    @(posedge mclk) frameStart <= 1;
    @(posedge mclk) frameStart <= 0;
    #1 chk("bulk", bulkActive, 1);
    @(posedge mclk) softReset <= 1;
    @(posedge mclk) softReset <= 0;
    rd(8'h04, 32'h7E0);
    @(posedge mclk) reset_n <= 0;
    @(posedge mclk) reset_n <= 1;
    #1 chk("hub", rootHubReset, 1);
    rd(8'h04, 0);
    end_sim;
  end
endmodule // hom_ctrl_test
`default_nettype wire
